// file: cpf_pkg.sv
// shared constants and types for the camera parallel input front end
package cpf_pkg;
   localparam logic [7:0] ADDR_UNIT_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_IF_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_VERSION = 8'h3c;
   localparam logic [7:0] ADDR_FRAME_COUNT = 8'h90;
   localparam logic [7:0] ADDR_PATTERN_LEN = 8'h30;
   // unit enable control fields
   localparam int EN_UNIT = 0;
   localparam int EN_PATTERN_ENABLE = 1;
   localparam int EN_COUNT = 2;
   localparam int EN_SAMPLE_POINT = 3;
   localparam int EN_PATTERN_GO = 4;
   localparam int EN_REPEAT_LO = 16;
   localparam int EN_VERSION = 30;
   localparam logic [31:0] EN_WRITE_MASK = 32'h40ff_001f;
   localparam logic [31:0] EN_RESET = 32'h0000_0000;
   // interface configuration fields
   localparam int CF_FORMAT_LO = 0;
   localparam int CF_WIDTH_LO = 8;
   localparam int CF_ORDER_LO = 10;
   localparam int CF_CLK_EDGE = 16;
   localparam int CF_HPOL = 17;
   localparam int CF_VPOL = 18;
   localparam int CF_FIELD = 19;
   localparam int CF_HALVE = 20;
   localparam int CF_SWAP = 23;
   localparam logic [31:0] CF_WRITE_MASK = 32'h00bf_0f9f;
   localparam logic [31:0] CF_RESET = 32'h0005_0000;
   // version value is arbitrary
   localparam logic [31:0] VERSION_CODE = 32'h0001_0000;
   localparam logic [1:0] WIDTH_8 = 2'b00;
   localparam logic [1:0] WIDTH_10 = 2'b01;
   localparam logic [1:0] WIDTH_12 = 2'b10;
   localparam logic [1:0] WIDTH_SPLIT = 2'b11;
   localparam logic [4:0] FMT_EMBEDDED_BASE = 5'b0_0100;
   localparam logic [4:0] FMT_EMBEDDED_LAST = 5'b0_0111;
   localparam logic [4:0] FMT_TWO_CHANNEL = 5'b0_1100;
   localparam logic [4:0] FMT_FOUR_CHANNEL = 5'b0_1101;
   localparam logic [1:0] PIX_SHIFT = 2'd2;
   typedef struct packed {
      logic [11:0] data;
      logic field;
      logic frame_start;
   } cpf_pixel_type;
   typedef struct packed {
      logic vsync;
      logic hsync;
      logic field;
      logic [11:0] data;
   } cpf_bus_type;
endpackage : cpf_pkg

// file: cpf_front_end.sv
// camera parallel input front end: registers, pixel sampling, buffering
//
// Contract
// [RULE1] unit enable bit zero holds capture logic in reset
// [RULE2] software sets pattern go; hardware clears it when replay ends
// [RULE3] pattern replays repeat count plus one times
// [RULE4] frame clock count sampled at frame end or vsync per sample bit; with embedded sync the code never samples it
// [RULE5] version register reads only while version read enable set
// [RULE6] swap bit routes the other parser's syncs and data here
// [RULE7] halving keeps first of every two frames; with embedded sync the code drops every frame
// [RULE8] separate sync: field bit selects field polarity
// [RULE9] embedded sync: field bit selects field order; the code fixes the field flag at the inverted field bit
// [RULE10] sync polarity bits, ignored for embedded sync
// [RULE11] clock edge bit: 0 falling, 1 rising
// [RULE12] split bus: two bytes from bits 11:4 into 10 bits at 11:2
// [RULE13] width field selects 8, 10, 12 or split bus
// [RULE14] format codes 0 to 7 separate or embedded timing formats
// [RULE15] codes 12 and 13 multi-channel embedded; others reserved
// [RULE16] reserved bits ignore writes and read zero
`timescale 1ns/100ps
`default_nettype none
module cpf_front_end #(
   parameter int PATTERN_WORDS = 16
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // sensor pins, own and neighbouring parser
   input wire logic PCLK,
   input wire cpf_pkg::cpf_bus_type OWN_BUS,
   input wire cpf_pkg::cpf_bus_type PEER_BUS,
   // pattern feed from memory
   input wire logic [11:0] PATTERN_DATA,
   output logic [7:0] PATTERN_ADDR,
   // pixel stream out
   output cpf_pkg::cpf_pixel_type PIX,
   output logic PIX_VALID,
   input wire logic PIX_READY,
   // mode status
   output logic EMBEDDED_SYNC,
   output logic [2:0] CHANNELS
);
   typedef enum {PAT_IDLE, PAT_RUN} cpf_pat_type;
   logic [31:0] en_reg;
   logic [31:0] cf_reg;
   logic [31:0] frame_count;
   logic [31:0] frame_sample;
   logic [31:0] pattern_len;
   cpf_pkg::cpf_bus_type bus_meta;
   cpf_pkg::cpf_bus_type bus_sync;
   logic pclk_meta;
   logic pclk_sync;
   logic pclk_prev;
   logic vs_prev;
   logic active;
   logic sample_edge;
   logic vs_act;
   logic hs_act;
   logic vs_rise;
   logic frame_done;
   logic embedded;
   logic byte_phase;
   logic [7:0] first_byte;
   logic frame_odd;
   logic field_now;
   logic [11:0] word;
   logic word_ok;
   logic pat_done;
   logic [7:0] cycles_left;
   logic [7:0] pat_index;
   cpf_pat_type pat_state;
   cpf_pkg::cpf_pixel_type buf_data [2];
   logic [1:0] buf_count;
   logic buf_rd;
   logic push;
   logic pop;
   cpf_pkg::cpf_pixel_type push_data;
   logic [1:0] width;
   logic [4:0] fmt;

   assign active = en_reg[cpf_pkg::EN_UNIT]; // RULE1
   assign width = cf_reg[cpf_pkg::CF_WIDTH_LO +: 2];
   assign fmt = cf_reg[cpf_pkg::CF_FORMAT_LO +: 5];
   assign embedded = (fmt >= cpf_pkg::FMT_EMBEDDED_BASE
      && fmt <= cpf_pkg::FMT_EMBEDDED_LAST)
      || fmt == cpf_pkg::FMT_TWO_CHANNEL
      || fmt == cpf_pkg::FMT_FOUR_CHANNEL; // RULE14 RULE15

   // register writes, reserved bits masked off
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         en_reg <= cpf_pkg::EN_RESET;
         cf_reg <= cpf_pkg::CF_RESET;
         pattern_len <= '0;
      end
      else
      begin
         if (WR && ADDR == cpf_pkg::ADDR_UNIT_ENABLE)
            en_reg <= WDATA & cpf_pkg::EN_WRITE_MASK; // RULE16
         else if (pat_done)
            en_reg[cpf_pkg::EN_PATTERN_GO] <= 1'b0; // RULE2
         if (WR && ADDR == cpf_pkg::ADDR_IF_CONFIG)
            cf_reg <= WDATA & cpf_pkg::CF_WRITE_MASK; // RULE16
         if (WR && ADDR == cpf_pkg::ADDR_PATTERN_LEN)
            pattern_len <= WDATA;
      end
   end

   // register reads, one cycle later
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         RDATA <= '0;
      else if (RD)
      begin
         case (ADDR)
            cpf_pkg::ADDR_UNIT_ENABLE: RDATA <= en_reg;
            cpf_pkg::ADDR_IF_CONFIG: RDATA <= cf_reg;
            cpf_pkg::ADDR_PATTERN_LEN: RDATA <= pattern_len;
            cpf_pkg::ADDR_FRAME_COUNT: RDATA <= frame_sample;
            cpf_pkg::ADDR_VERSION:
               RDATA <= en_reg[cpf_pkg::EN_VERSION] ?
                  cpf_pkg::VERSION_CODE : '0; // RULE5
            default: RDATA <= '0;
         endcase
      end
      else
         RDATA <= '0;
   end

   // two-stage synchronisers for pins
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         pclk_meta <= 1'b0;
         pclk_sync <= 1'b0;
         pclk_prev <= 1'b0;
         bus_meta <= '0;
         bus_sync <= '0;
      end
      else
      begin
         pclk_meta <= PCLK;
         pclk_sync <= pclk_meta;
         pclk_prev <= pclk_sync;
         bus_meta <= cf_reg[cpf_pkg::CF_SWAP] ? PEER_BUS : OWN_BUS; // RULE6
         bus_sync <= bus_meta;
      end
   end

   assign sample_edge = cf_reg[cpf_pkg::CF_CLK_EDGE] ?
      (pclk_sync && !pclk_prev) : (!pclk_sync && pclk_prev); // RULE11
   // embedded timing has no sync pins: polarity ignored
   assign vs_act = embedded ? 1'b0 :
      !(bus_sync.vsync ^ cf_reg[cpf_pkg::CF_VPOL]); // RULE10
   assign hs_act = embedded ? 1'b0 :
      !(bus_sync.hsync ^ cf_reg[cpf_pkg::CF_HPOL]); // RULE10
   assign vs_rise = sample_edge && vs_act && !vs_prev;
   assign frame_done = sample_edge && !vs_act && vs_prev;
   // separate sync: polarity; embedded: field order
   // frame_odd is high in the first field after enable with separate sync; embedded sync leaves it low
   assign field_now = embedded ?
      (!frame_odd ^ cf_reg[cpf_pkg::CF_FIELD]) : // RULE9
      !(bus_sync.field ^ cf_reg[cpf_pkg::CF_FIELD]); // RULE8

   // frame tracking, halving, clock counter
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         vs_prev <= 1'b0;
         frame_odd <= 1'b0;
         frame_count <= '0;
         frame_sample <= '0;
      end
      else if (!active)
      begin
         vs_prev <= 1'b0;
         frame_odd <= 1'b0;
         frame_count <= '0;
         frame_sample <= '0;
      end
      else
      begin
         if (sample_edge)
            vs_prev <= vs_act;
         if (vs_rise)
            frame_odd <= !frame_odd; // RULE7
         if (en_reg[cpf_pkg::EN_COUNT])
         begin
            if ((en_reg[cpf_pkg::EN_SAMPLE_POINT] && vs_rise)
               || (!en_reg[cpf_pkg::EN_SAMPLE_POINT] && frame_done))
            begin
               frame_sample <= frame_count; // RULE4
               frame_count <= '0;
            end
            else
               frame_count <= frame_count + 32'h0000_0001;
         end
      end
   end

   // bus width and split-bus byte assembly
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         byte_phase <= 1'b0;
         first_byte <= '0;
         word <= '0;
         word_ok <= 1'b0;
      end
      else if (!active || !hs_act && !embedded)
      begin
         byte_phase <= 1'b0;
         word_ok <= 1'b0;
      end
      else
      begin
         word_ok <= 1'b0;
         if (sample_edge)
         begin
            case (width) // RULE13
               cpf_pkg::WIDTH_8:
               begin
                  word <= {bus_sync.data[11:4], 4'h0};
                  word_ok <= 1'b1;
               end
               cpf_pkg::WIDTH_10:
               begin
                  word <= {bus_sync.data[11:2], 2'b00};
                  word_ok <= 1'b1;
               end
               cpf_pkg::WIDTH_12:
               begin
                  word <= bus_sync.data;
                  word_ok <= 1'b1;
               end
               default:
               begin
                  byte_phase <= !byte_phase;
                  if (!byte_phase)
                     first_byte <= bus_sync.data[11:4];
                  else
                  begin
                     word_ok <= 1'b1;
                     case (cf_reg[cpf_pkg::CF_ORDER_LO +: 2]) // RULE12
                        2'b00: word <= {first_byte[1:0],
                           bus_sync.data[11:4], 2'b00};
                        2'b01: word <= {first_byte,
                           bus_sync.data[5:4], 2'b00};
                        2'b10: word <= {bus_sync.data[11:10],
                           first_byte, 2'b00};
                        default: word <= {bus_sync.data[5:4],
                           first_byte, 2'b00};
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // pattern replay from memory
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         pat_state <= PAT_IDLE;
         pat_index <= '0;
         cycles_left <= '0;
         pat_done <= 1'b0;
      end
      else if (!active)
      begin
         pat_state <= PAT_IDLE;
         pat_index <= '0;
         pat_done <= 1'b0;
      end
      else
      begin
         pat_done <= 1'b0;
         case (pat_state)
            PAT_IDLE:
               if (en_reg[cpf_pkg::EN_PATTERN_GO] && !pat_done
                  && en_reg[cpf_pkg::EN_PATTERN_ENABLE])
               begin
                  pat_state <= PAT_RUN;
                  pat_index <= '0;
                  cycles_left <= en_reg[cpf_pkg::EN_REPEAT_LO +: 8]; // RULE3
               end
            PAT_RUN:
               if (push)
               begin
                  if (pat_index == 8'(PATTERN_WORDS - 1))
                  begin
                     pat_index <= '0;
                     if (cycles_left == '0)
                     begin
                        pat_state <= PAT_IDLE;
                        pat_done <= 1'b1; // RULE2
                     end
                     else
                        cycles_left <= cycles_left - 8'h01; // RULE3
                  end
                  else
                     pat_index <= pat_index + 8'h01;
               end
            default: pat_state <= PAT_IDLE;
         endcase
      end
   end

   // stream mux into two-entry buffer
   always_comb
   begin
      push_data.data = word;
      push_data.field = field_now;
      push_data.frame_start = 1'b0;
      push = 1'b0;
      if (pat_state == PAT_RUN)
      begin
         push_data.data = PATTERN_DATA;
         push_data.frame_start = (pat_index == '0);
         push = buf_count != 2'd2;
      end
      else if (word_ok && !(cf_reg[cpf_pkg::CF_HALVE] && !frame_odd)) // RULE7
         push = buf_count != 2'd2;
   end
   assign pop = PIX_VALID && PIX_READY;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         buf_count <= '0;
         buf_rd <= 1'b0;
         buf_data[0] <= '0;
         buf_data[1] <= '0;
      end
      else if (!active)
      begin
         buf_count <= '0;
         buf_rd <= 1'b0;
      end
      else
      begin
         if (push)
            buf_data[buf_rd ^ buf_count[0]] <= push_data;
         if (pop)
            buf_rd <= !buf_rd;
         buf_count <= buf_count + 2'(push) - 2'(pop);
      end
   end

   // registered outputs
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         PIX <= '0;
         PIX_VALID <= 1'b0;
         PATTERN_ADDR <= '0;
         EMBEDDED_SYNC <= 1'b0;
         CHANNELS <= 3'd1;
      end
      else
      begin
         PIX_VALID <= active && (buf_count - 2'(pop)) != 2'd0;
         PIX <= pop ? buf_data[!buf_rd] : buf_data[buf_rd];
         PATTERN_ADDR <= pat_index;
         EMBEDDED_SYNC <= embedded;
         CHANNELS <= fmt == cpf_pkg::FMT_FOUR_CHANNEL ? 3'd4 :
            fmt == cpf_pkg::FMT_TWO_CHANNEL ? 3'd2 : 3'd1; // RULE15
      end
   end
endmodule : cpf_front_end
`default_nettype wire

// file: cpf_front_end_properties.sv
// assertions on the front end ports
`timescale 1ns/100ps
`default_nettype none
module cpf_front_end_properties #(
   parameter int PATTERN_WORDS = 16
) (
   // clock, reset, register port
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // sensor and pattern side
   input wire logic PCLK,
   input wire cpf_pkg::cpf_bus_type OWN_BUS,
   input wire cpf_pkg::cpf_bus_type PEER_BUS,
   input wire logic [11:0] PATTERN_DATA,
   input wire logic [7:0] PATTERN_ADDR,
   // stream and status
   input wire cpf_pkg::cpf_pixel_type PIX,
   input wire logic PIX_VALID,
   input wire logic PIX_READY,
   input wire logic EMBEDDED_SYNC,
   input wire logic [2:0] CHANNELS
);
   logic version_read_enable;
   logic unit_en;
   logic [31:0] cfg;
   logic cfg_wr;
   logic [4:0] fmt;
   logic emb;
   logic known;
   logic [2:0] chn;
   assign cfg_wr = WR && ADDR == cpf_pkg::ADDR_IF_CONFIG;
   assign fmt = cfg[4:0];
   assign emb = fmt inside {[5'h4:5'h7], 5'hc, 5'hd};
   assign known = emb || fmt < 5'h4;
   assign chn = fmt == 5'hc ? 3'h2 : fmt == 5'hd ? 3'h4 : 3'h1;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // shadow of the enable bits
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN)
      begin
         version_read_enable <= 1'b0;
         unit_en <= 1'b0;
      end
      else if (WR && ADDR == cpf_pkg::ADDR_UNIT_ENABLE)
      begin
         version_read_enable <= WDATA[cpf_pkg::EN_VERSION];
         unit_en <= WDATA[cpf_pkg::EN_UNIT];
      end
   // shadow of the interface configuration
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN)
         cfg <= cpf_pkg::CF_RESET;
      else if (cfg_wr)
         cfg <= WDATA & cpf_pkg::CF_WRITE_MASK;
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data not zero outside a read");
   version_gate_a: assert property (
      RD && ADDR == cpf_pkg::ADDR_VERSION |=> RDATA ==
      ($past(version_read_enable) ? cpf_pkg::VERSION_CODE : 32'h0000_0000))
      else $error("version read not gated by its enable");
   enable_read_a: assert property (
      RD && ADDR == cpf_pkg::ADDR_UNIT_ENABLE |=>
      (RDATA & ~cpf_pkg::EN_WRITE_MASK) == 32'h0000_0000 &&
      RDATA[0] == $past(unit_en) && RDATA[30] == $past(version_read_enable))
      else $error("enable register read back wrong");
   config_read_a: assert property (
      RD && ADDR == cpf_pkg::ADDR_IF_CONFIG |=> RDATA == $past(cfg))
      else $error("configuration read back wrong");
   pixel_hold_a: assert property (
      PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX))
      else $error("stalled pixel changed or dropped");
   unit_off_a: assert property ((!unit_en) [*4] |-> !PIX_VALID)
      else $error("pixels while unit disabled");
   sync_mode_a: assert property (
      known && !$past(cfg_wr) |-> EMBEDDED_SYNC == emb)
      else $error("embedded sync flag wrong for format");
   channel_count_a: assert property (
      known && !$past(cfg_wr) |-> CHANNELS == chn)
      else $error("channel count wrong for format");
   pattern_range_a: assert property (
      PATTERN_ADDR < PATTERN_WORDS)
      else $error("pattern address beyond pattern length");
endmodule : cpf_front_end_properties
bind cpf_front_end cpf_front_end_properties #(
   .PATTERN_WORDS(PATTERN_WORDS)
) i_cpf_front_end_properties (
   .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .PCLK(PCLK), .OWN_BUS(OWN_BUS),
   .PEER_BUS(PEER_BUS), .PATTERN_DATA(PATTERN_DATA),
   .PATTERN_ADDR(PATTERN_ADDR), .PIX(PIX), .PIX_VALID(PIX_VALID),
   .PIX_READY(PIX_READY), .EMBEDDED_SYNC(EMBEDDED_SYNC),
   .CHANNELS(CHANNELS)
);
`default_nettype wire

// file: cpf_sensor_model.sv
// behavioural camera sensor: pixel clock, syncs and data
`timescale 1ns/100ps
`default_nettype none
module cpf_sensor_model (
   // pins toward the front end
   output logic PCLK,
   output cpf_pkg::cpf_bus_type BUS
);
   logic rise;
   initial
   begin
      rise = 1'b1;
      PCLK = 1'b1;
      BUS = '{vsync: 1'b0, hsync: 1'b1, field: 1'b0, data: 12'h000};
   end
   // launch on the edge the receiver does not sample
   task tick(input logic v, input logic h, input logic [11:0] d);
      PCLK = !rise;
      BUS.vsync = v;
      BUS.hsync = h;
      BUS.data = d;
      #40;
      PCLK = rise;
      #40;
   endtask : tick
   // one line; vsync high, hsync low active; data inverted in blanking
   task frame(input int n, input logic [11:0] base, input logic split);
      logic [11:0] d;
      repeat (2) tick(1'b1, 1'b1, ~BUS.data);
      for (int i = 0; i < n; i++)
      begin
         d = base + 12'(i);
         if (split)
         begin
            tick(1'b1, 1'b0, {6'h00, d[9:8], 4'h0});
            tick(1'b1, 1'b0, {d[7:0], 4'h0});
         end
         else
            tick(1'b1, 1'b0, d);
      end
      repeat (2) tick(1'b1, 1'b1, ~BUS.data);
      repeat (2) tick(1'b0, 1'b1, ~BUS.data);
   endtask : frame
endmodule : cpf_sensor_model
`default_nettype wire

// file: cpf_front_end_test.sv
// self-checking bench for the camera parallel front end
`timescale 1ns/100ps
`default_nettype none
module cpf_front_end_test;
   localparam int WORDS = 4;
   logic clk;
   logic resetn;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic pclk;
   cpf_pkg::cpf_bus_type own_bus;
   cpf_pkg::cpf_bus_type peer_bus;
   logic [11:0] pat_data;
   logic [7:0] pat_addr;
   cpf_pkg::cpf_pixel_type pix;
   logic pix_valid;
   logic pix_ready;
   logic emb;
   logic [2:0] chans;
   logic [1:0] stall;
   logic [11:0] got[$];
   logic [31:0] r;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   cpf_front_end #(.PATTERN_WORDS(WORDS)) i_cpf_front_end (
      .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .PCLK(pclk), .OWN_BUS(own_bus),
      .PEER_BUS(peer_bus), .PATTERN_DATA(pat_data),
      .PATTERN_ADDR(pat_addr), .PIX(pix), .PIX_VALID(pix_valid),
      .PIX_READY(pix_ready), .EMBEDDED_SYNC(emb), .CHANNELS(chans)
   );
   cpf_sensor_model i_cpf_sensor_model (.PCLK(pclk), .BUS(own_bus));
   cpf_sensor_model i_cpf_sensor_model_peer (.PCLK(), .BUS(peer_bus));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // receiver stalls one cycle in four; memory answers a cycle late
   always @(posedge clk)
   begin
      stall <= stall + 2'h1;
      pix_ready <= stall != 2'h0;
      pat_data <= {4'h0, pat_addr};
      if (pix_valid && pix_ready)
         got.push_back(pix.data);
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize();
      end
   end
   task summarize;
      if (n_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task chk_pix(input logic [11:0] g, input logic [11:0] e);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD t=%0t pixel %h exp %h", $time, g, e);
      end
   endtask : chk_pix
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   task run(input int n, input logic [11:0] b, input logic s);
      i_cpf_sensor_model.frame(n, b, s);
      repeat (30) @(posedge clk);
   endtask : run
   // compare and drop the collected pixels
   task frame_chk(input int n, input logic [11:0] b, input logic s);
      chk(32'(got.size()), 32'(n));
      for (int i = 0; i < n && i < got.size(); i++)
         chk_pix(got[i], s ? {b[9:0] + 10'(i), 2'h0} : b + 12'(i));
      got.delete();
   endtask : frame_chk
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
      stall = 2'h0;
      pix_ready = 1'b0;
      pat_data = 12'h000;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rd_reg(cpf_pkg::ADDR_UNIT_ENABLE, r);
      chk(r, cpf_pkg::EN_RESET);
      rd_reg(cpf_pkg::ADDR_IF_CONFIG, r);
      chk(r, cpf_pkg::CF_RESET);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'hffff_ffef);
      rd_reg(cpf_pkg::ADDR_UNIT_ENABLE, r);
      chk(r, 32'h40ff_000f);
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'hffff_ffff);
      rd_reg(cpf_pkg::ADDR_IF_CONFIG, r);
      chk(r, cpf_pkg::CF_WRITE_MASK);
      rd_reg(cpf_pkg::ADDR_VERSION, r);
      chk(r, cpf_pkg::VERSION_CODE);
      rd_reg(8'hfc, r);
      chk(r, 32'h0000_0000);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'h0000_0000);
      rd_reg(cpf_pkg::ADDR_VERSION, r);
      chk(r, 32'h0000_0000);
      for (int c = 0; c < 14; c++)
         if (c < 8 || c > 11)
            wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'(c));
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'h0005_0200);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'h0000_0001);
      got.delete();
      run(6, 12'h5a0, 1'b0);
      frame_chk(6, 12'h5a0, 1'b0);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'h0000_0000);
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'h0015_0200);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'h0000_0001);
      run(4, 12'h100, 1'b0);
      run(4, 12'h200, 1'b0);
      frame_chk(4, 12'h100, 1'b0);
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'h0005_0300);
      run(5, 12'h2c3, 1'b1);
      frame_chk(5, 12'h2c3, 1'b1);
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'h0004_0200);
      i_cpf_sensor_model.rise = 1'b0;
      run(4, 12'h444, 1'b0);
      frame_chk(4, 12'h444, 1'b0);
      i_cpf_sensor_model.rise = 1'b1;
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'h0085_0200);
      fork
         run(3, 12'h0a0, 1'b0);
         i_cpf_sensor_model_peer.frame(3, 12'h0f0, 1'b0);
      join
      frame_chk(3, 12'h0f0, 1'b0);
      wr_reg(cpf_pkg::ADDR_IF_CONFIG, 32'h0005_0200);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'h0000_0000);
      run(3, 12'h300, 1'b0);
      frame_chk(0, 12'h300, 1'b0);
      wr_reg(cpf_pkg::ADDR_UNIT_ENABLE, 32'h0001_0013);
      r = 32'h0000_0010;
      for (int k = 0; k < 200 && r[4] !== 1'b0; k++)
         rd_reg(cpf_pkg::ADDR_UNIT_ENABLE, r);
      chk({31'h0, r[4]}, 32'h0000_0000);
      repeat (30) @(posedge clk);
      chk(32'(got.size()), 32'(2 * WORDS));
      summarize();
   end
endmodule : cpf_front_end_test
`default_nettype wire
